/* File: ucil_consts.svh */
/*
 * Constants for the serial channel interrupt and line control block:
 * register offsets, field positions, reset values, identification codes.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef UCIL_CONSTS_SVH
`define UCIL_CONSTS_SVH

// Register offsets (3-bit channel address)
`define UCIL_OFS_DATA      3'h0
`define UCIL_OFS_IEN       3'h1
`define UCIL_OFS_IID       3'h2
`define UCIL_OFS_LCTL      3'h3
`define UCIL_OFS_LSTAT     3'h5
`define UCIL_OFS_MSTAT     3'h6
`define UCIL_OFS_SCR       3'h7

// Interrupt enable fields
`define UCIL_IEN_RX        0
`define UCIL_IEN_TX        1
`define UCIL_IEN_LS        2
`define UCIL_IEN_MS        3
`define UCIL_IEN_RST       8'h00

// Line control fields
`define UCIL_LC_WLEN_LO    0
`define UCIL_LC_WLEN_HI    1
`define UCIL_LC_STOP       2
`define UCIL_LC_PEN        3
`define UCIL_LC_EPS        4
`define UCIL_LC_STICK      5
`define UCIL_LC_BREAK      6
`define UCIL_LC_DIV_ACCESS 7
`define UCIL_LC_RST        8'h00

// FIFO control fields
`define UCIL_FC_EN         0
`define UCIL_FC_TRIG_LO    6
`define UCIL_FC_TRIG_HI    7

// Trigger levels
`define UCIL_TRIG_1        5'h01
`define UCIL_TRIG_4        5'h04
`define UCIL_TRIG_8        5'h08
`define UCIL_TRIG_14       5'h0E

// Identification codes, bits 3..0
`define UCIL_ID_NONE       4'h1
`define UCIL_ID_LS         4'h6
`define UCIL_ID_RX         4'h4
`define UCIL_ID_TO         4'hC
`define UCIL_ID_TX         4'h2
`define UCIL_ID_MS         4'h0

// Time-out length in character times
`define UCIL_TO_CHARS      3'h4
// Baud ticks (16x) per bit
`define UCIL_TICKS_PER_BIT 5'h10

`endif

/* File: ucil_pkg.sv */
/*
 * Types for the serial channel interrupt and line control block.
 * Assumes ucil_consts.svh on the include path.
 */
`include "ucil_consts.svh"

package ucil_pkg;

  // Interrupt source ranked highest first
  typedef enum logic [2:0]
  {
    UCIL_SRC_NONE = 3'h0,
    UCIL_SRC_LS   = 3'h1,
    UCIL_SRC_RX   = 3'h3,
    UCIL_SRC_TO   = 3'h2,
    UCIL_SRC_TX   = 3'h6,
    UCIL_SRC_MS   = 3'h7
  } ucil_src_t;

  // Transmit-empty delay states, Gray along the path
  typedef enum logic [1:0]
  {
    UCIL_TE_IDLE = 2'b00,
    UCIL_TE_WAIT = 2'b01,
    UCIL_TE_DONE = 2'b11
  } ucil_te_t;

endpackage

/* File: ucil_char_timer.sv */
/*
 * Character-time timer: counts baud ticks into character times and
 * flags when a programmed number of character times have passed.
 * Assumes a one-cycle baud tick enable at sixteen ticks per bit.
 */
`timescale 1ns/1ps

module ucil_char_timer
#(
  parameter int CW = 12
)
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Control
  input  wire logic          restart,
  input  wire logic          run,
  input  wire logic          tick,
  input  wire logic [CW-1:0] ticks_per_char,
  input  wire logic [2:0]    chars,
  // Result
  output logic               expired
);

  logic [CW-1:0] tick_cnt_ff;
  logic [2:0]    char_cnt_ff;

  //////////////////////////////////////////////////////////////////////////
  // Tick and character counters; restart wins over counting
  always_ff @(posedge clk)
  begin
    if (rst || restart || !run)
    begin
      tick_cnt_ff <= '0;
      char_cnt_ff <= 3'h0;
    end
    else if (tick && char_cnt_ff != chars)
    begin
      if (tick_cnt_ff + 1'b1 >= ticks_per_char)
      begin
        tick_cnt_ff <= '0;
        char_cnt_ff <= char_cnt_ff + 3'h1;
      end
      else
        tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  // Stays high until restarted or stopped
  assign expired = run && (char_cnt_ff == chars) && (chars != 3'h0);

endmodule

/* File: ucil_prio.sv */
/*
 * Interrupt priority encoder: picks the highest pending source and
 * gives its identification code.
 * Assumes pending inputs already gated by their enables.
 */
`timescale 1ns/1ps
`include "ucil_consts.svh"

module ucil_prio
  import ucil_pkg::*;
(
  // Pending sources
  input  wire logic  ls,
  input  wire logic  rx,
  input  wire logic  to,
  input  wire logic  tx,
  input  wire logic  ms,
  // Result
  output ucil_src_t  src,
  output logic [3:0] code
);

  // Fixed five-level ranking; time-out ranks just below receive data
  always_comb
  begin
    if (ls)
    begin
      src  = UCIL_SRC_LS;
      code = `UCIL_ID_LS;
    end
    else if (rx)
    begin
      src  = UCIL_SRC_RX;
      code = `UCIL_ID_RX;
    end
    else if (to)
    begin
      src  = UCIL_SRC_TO;
      code = `UCIL_ID_TO;
    end
    else if (tx)
    begin
      src  = UCIL_SRC_TX;
      code = `UCIL_ID_TX;
    end
    else if (ms)
    begin
      src  = UCIL_SRC_MS;
      code = `UCIL_ID_MS;
    end
    else
    begin
      src  = UCIL_SRC_NONE;
      code = `UCIL_ID_NONE;
    end
  end

endmodule

/* File: ucil_ctrl.sv */
/*
 * Serial channel interrupt and line control block.
 * Holds interrupt enable, line control and FIFO control state, ranks
 * interrupt sources, builds the identification register, times receive
 * character time-out and delays transmit-empty indications.
 * Assumes the FIFO datapath, serialiser and status logic sit outside on
 * the same clock and report through plain status and pulse inputs.
 */
`timescale 1ns/1ps
`include "ucil_consts.svh"

module ucil_ctrl
  import ucil_pkg::*;
#(
  parameter int CW = 12
)
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Register port
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic [7:0]      RDATA,
  // Channel status from the datapath
  input  wire logic       BAUD_TICK,
  input  wire logic [4:0] RX_LEVEL,
  input  wire logic       RX_CHAR_IN,
  input  wire logic       RX_DATA_READY,
  input  wire logic       LS_EVENT,
  input  wire logic       MS_EVENT,
  input  wire logic       TX_FIFO_EMPTY,
  input  wire logic       TX_FIFO_PUSH,
  input  wire logic       TX_STOP_START,
  input  wire logic       TX_SERIAL_RAW,
  input  wire logic [7:0] LINE_STATUS_IN,
  input  wire logic [7:0] MODEM_STATUS_IN,
  // Register strobes to the datapath
  output logic            RX_POP,
  output logic            TX_WRITE,
  output logic [7:0]      TX_DATA,
  output logic [7:0]      DIVISOR_LOW,
  output logic [7:0]      DIVISOR_HIGH,
  // Format to the serialisers
  output logic [1:0]      WORD_LENGTH,
  output logic            TWO_STOP_BITS,
  output logic            PARITY_ENABLE,
  output logic            PARITY_EVEN,
  output logic            PARITY_STICK,
  output logic            PARITY_STICK_VALUE,
  output logic            FIFO_ENABLE,
  output logic            HOLDING_EMPTY_FLAG,
  // Line and interrupt
  output logic            SERIAL_TRANSMIT_OUT,
  output logic            CHANNEL_INTERRUPT_OUT
);

  logic [3:0]  ien_ff;
  logic [7:0]  lctl_ff;
  logic        fifo_en_ff;
  logic [1:0]  trig_sel_ff;
  logic [7:0]  scratch_ff;
  logic [7:0]  rdata_ff;
  logic        ls_pend_ff;
  logic        ms_pend_ff;
  logic        to_pend_ff;
  logic        tx_pend_ff;
  logic        tx_seen_empty_ff;
  logic [1:0]  tx_bytes_ff;
  ucil_te_t    te_state_ff;
  logic        rx_pop_ff;
  logic        tx_write_ff;
  logic [7:0]  tx_data_ff;
  logic [7:0]  div_lo_ff;
  logic [7:0]  div_hi_ff;
  logic        txo_ff;
  logic        int_ff;
  logic        hold_empty_ff;
  logic        tx_empty_ind;
  logic        rx_hit;
  logic        to_expired;
  logic        te_expired;
  logic        any_en;
  logic        div_access;
  logic [4:0]  trig_level;
  logic [3:0]  id_code;
  ucil_src_t   top_src;
  logic [7:0]  iid_value;
  logic [CW-1:0] ticks_char;
  logic [CW-1:0] ticks_te;
  logic [3:0]  bits_char;
  logic        wr_data;
  logic        rd_data;
  logic        rd_iid;
  logic        rd_lstat;
  logic        rd_mstat;
  logic        wr_fctl;

  //////////////////////////////////////////////////////////////////////////
  // Decode of the register port
  assign div_access = lctl_ff[`UCIL_LC_DIV_ACCESS];
  assign wr_data  = WR && ADDR == `UCIL_OFS_DATA && !div_access;
  assign rd_data  = RD && ADDR == `UCIL_OFS_DATA && !div_access;
  assign rd_iid   = RD && ADDR == `UCIL_OFS_IID;
  assign wr_fctl  = WR && ADDR == `UCIL_OFS_IID;
  assign rd_lstat = RD && ADDR == `UCIL_OFS_LSTAT;
  assign rd_mstat = RD && ADDR == `UCIL_OFS_MSTAT;
  assign any_en   = |ien_ff;

  // Interrupt enable, upper bits not stored so they read zero
  always_ff @(posedge CLK)
  begin
    if (RST)
      ien_ff <= 4'h0;
    else if (WR && ADDR == `UCIL_OFS_IEN && !div_access)
      ien_ff <= WDATA[3:0];
  end

  // Line control and scratch
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      lctl_ff    <= `UCIL_LC_RST;
      scratch_ff <= 8'h00;
    end
    else if (WR && ADDR == `UCIL_OFS_LCTL)
      lctl_ff <= WDATA;
    else if (WR && ADDR == `UCIL_OFS_SCR)
      scratch_ff <= WDATA;
  end

  // FIFO control; other bits only take effect with FIFOs enabled
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      fifo_en_ff  <= 1'b0;
      trig_sel_ff <= 2'b00;
    end
    else if (wr_fctl)
    begin
      fifo_en_ff <= WDATA[`UCIL_FC_EN];
      if (WDATA[`UCIL_FC_EN])
        trig_sel_ff <= WDATA[`UCIL_FC_TRIG_HI:`UCIL_FC_TRIG_LO];
    end
  end

  // Divisor bytes, reachable only with the access bit set
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      div_lo_ff <= 8'h00;
      div_hi_ff <= 8'h00;
    end
    else if (WR && div_access && ADDR == `UCIL_OFS_DATA)
      div_lo_ff <= WDATA;
    else if (WR && div_access && ADDR == `UCIL_OFS_IEN)
      div_hi_ff <= WDATA;
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive trigger level and data-available condition
  always_comb
  begin
    unique case (trig_sel_ff)
      2'b00: trig_level = `UCIL_TRIG_1;
      2'b01: trig_level = `UCIL_TRIG_4;
      2'b10: trig_level = `UCIL_TRIG_8;
      2'b11: trig_level = `UCIL_TRIG_14;
    endcase
  end

  // Level-based so it drops itself once reads bring the FIFO under trigger
  assign rx_hit = fifo_en_ff ? (RX_LEVEL >= trig_level)
                             : RX_DATA_READY;

  // Character length in bits: start, data, parity, stop
  assign bits_char = 4'h7 + {2'b00, lctl_ff[1:0]}
                     + {3'b000, lctl_ff[`UCIL_LC_PEN]}
                     + {3'b000, lctl_ff[`UCIL_LC_STOP]};
  assign ticks_char = CW'(bits_char) * CW'(`UCIL_TICKS_PER_BIT);
  assign ticks_te   = ticks_char - CW'(`UCIL_TICKS_PER_BIT);

  // A read always restarts; a character only while none pending
  ucil_char_timer #(.CW(CW)) u_to_timer
  (
    .clk            (CLK),
    .rst            (RST),
    .restart        (rd_data || (RX_CHAR_IN && !to_pend_ff)),
    .run            (fifo_en_ff && RX_LEVEL != 5'h00),
    .tick           (BAUD_TICK),
    .ticks_per_char (ticks_char),
    .chars          (`UCIL_TO_CHARS),
    .expired        (to_expired)
  );

  // Time-out pending; a read clears it and the timer is restarted
  always_ff @(posedge CLK)
  begin
    if (RST || !fifo_en_ff)
      to_pend_ff <= 1'b0;
    else if (rd_data)
      to_pend_ff <= 1'b0;
    else if (to_expired)
      to_pend_ff <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Bytes seen in transmit FIFO since last holding-empty set, saturating
  always_ff @(posedge CLK)
  begin
    if (RST || hold_empty_ff && !TX_FIFO_EMPTY && tx_bytes_ff == 2'h0)
      tx_bytes_ff <= 2'h0;
    else if (TX_FIFO_PUSH && tx_bytes_ff != 2'h2)
      tx_bytes_ff <= tx_bytes_ff + 2'h1;
    else if (tx_empty_ind && !hold_empty_ff)
      tx_bytes_ff <= 2'h0;
  end

  // Delay of the empty indication: one character less the stop bit
  always_ff @(posedge CLK)
  begin
    if (RST || !TX_FIFO_EMPTY)
      te_state_ff <= UCIL_TE_IDLE;
    else
    begin
      unique case (te_state_ff)
        UCIL_TE_IDLE:
          if (!fifo_en_ff || tx_bytes_ff == 2'h2)
            te_state_ff <= UCIL_TE_DONE;
          else if (TX_STOP_START)
            te_state_ff <= UCIL_TE_WAIT;
        UCIL_TE_WAIT:
          if (te_expired)
            te_state_ff <= UCIL_TE_DONE;
        UCIL_TE_DONE:
          te_state_ff <= UCIL_TE_DONE;
        default:
          te_state_ff <= UCIL_TE_IDLE;
      endcase
    end
  end

  ucil_char_timer #(.CW(CW)) u_te_timer
  (
    .clk            (CLK),
    .rst            (RST),
    .restart        (1'b0),
    .run            (te_state_ff == UCIL_TE_WAIT),
    .tick           (BAUD_TICK),
    .ticks_per_char (ticks_te),
    .chars          (3'h1),
    .expired        (te_expired)
  );

  assign tx_empty_ind = TX_FIFO_EMPTY && te_state_ff == UCIL_TE_DONE;

  // Holding-empty flag follows the delayed indication
  always_ff @(posedge CLK)
  begin
    if (RST)
      hold_empty_ff <= 1'b1;
    else if (wr_data)
      hold_empty_ff <= 1'b0;
    else if (tx_empty_ind || !fifo_en_ff && TX_FIFO_EMPTY)
      hold_empty_ff <= 1'b1;
  end

  // Transmit interrupt pending; new empty edge or mode change sets it
  always_ff @(posedge CLK)
  begin
    if (RST)
      tx_pend_ff <= 1'b0;
    else if (wr_fctl && WDATA[`UCIL_FC_EN] != fifo_en_ff)
      tx_pend_ff <= 1'b1;
    else if (tx_empty_ind && !tx_seen_empty_ff)
      tx_pend_ff <= 1'b1;
    else if (wr_data || rd_iid && top_src == UCIL_SRC_TX)
      tx_pend_ff <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      tx_seen_empty_ff <= 1'b1;
    else
      tx_seen_empty_ff <= tx_empty_ind;
  end

  //////////////////////////////////////////////////////////////////////////
  // Line status and modem pending; a new event beats the clearing read
  always_ff @(posedge CLK)
  begin
    if (RST)
      ls_pend_ff <= 1'b0;
    else if (LS_EVENT)
      ls_pend_ff <= 1'b1;
    else if (rd_lstat)
      ls_pend_ff <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      ms_pend_ff <= 1'b0;
    else if (MS_EVENT)
      ms_pend_ff <= 1'b1;
    else if (rd_mstat)
      ms_pend_ff <= 1'b0;
  end

  // Ranking with each source gated by its enable
  ucil_prio u_prio
  (
    .ls   (ls_pend_ff && ien_ff[`UCIL_IEN_LS]),
    .rx   (rx_hit && ien_ff[`UCIL_IEN_RX]),
    .to   (to_pend_ff && ien_ff[`UCIL_IEN_RX]),
    .tx   (tx_pend_ff && ien_ff[`UCIL_IEN_TX]),
    .ms   (ms_pend_ff && ien_ff[`UCIL_IEN_MS]),
    .src  (top_src),
    .code (id_code)
  );

  // Identification value; bit3 only in FIFO mode
  assign iid_value = {fifo_en_ff, fifo_en_ff, 2'b00,
                      id_code[3] && fifo_en_ff, id_code[2:0]};

  //////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe only
  always_ff @(posedge CLK)
  begin
    if (RST || !RD)
      rdata_ff <= 8'h00;
    else
    begin
      unique case (ADDR)
        `UCIL_OFS_DATA:  rdata_ff <= 8'h00;
        `UCIL_OFS_IEN:   rdata_ff <= div_access ? div_hi_ff : {4'h0, ien_ff};
        `UCIL_OFS_IID:   rdata_ff <= any_en ? iid_value
                                   : {fifo_en_ff, fifo_en_ff, 6'h01};
        `UCIL_OFS_LCTL:  rdata_ff <= lctl_ff;
        3'h4:            rdata_ff <= 8'h00;
        `UCIL_OFS_LSTAT: rdata_ff <= {LINE_STATUS_IN[7:6], hold_empty_ff,
                                      LINE_STATUS_IN[4:0]};
        `UCIL_OFS_MSTAT: rdata_ff <= MODEM_STATUS_IN;
        `UCIL_OFS_SCR:   rdata_ff <= scratch_ff;
      endcase
      if (ADDR == `UCIL_OFS_DATA && div_access)
        rdata_ff <= div_lo_ff;
    end
  end

  // Datapath strobes registered so every output but PARITY_STICK_VALUE is a flip-flop
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      rx_pop_ff   <= 1'b0;
      tx_write_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
    end
    else
    begin
      rx_pop_ff   <= rd_data;
      tx_write_ff <= wr_data;
      if (wr_data)
        tx_data_ff <= WDATA;
    end
  end

  // Break forces spacing on the pin only; a cycle of latency is harmless
  always_ff @(posedge CLK)
  begin
    if (RST)
      txo_ff <= 1'b1;
    else
      txo_ff <= TX_SERIAL_RAW && !lctl_ff[`UCIL_LC_BREAK];
  end

  // Interrupt output, active high, silent with all sources disabled
  always_ff @(posedge CLK)
  begin
    if (RST)
      int_ff <= 1'b0;
    else
      int_ff <= any_en && top_src != UCIL_SRC_NONE;
  end

  //////////////////////////////////////////////////////////////////////////
  // Output assignments; format fields from line control, stick value inverted
  assign RDATA                 = rdata_ff;
  assign RX_POP                = rx_pop_ff;
  assign TX_WRITE              = tx_write_ff;
  assign TX_DATA               = tx_data_ff;
  assign DIVISOR_LOW           = div_lo_ff;
  assign DIVISOR_HIGH          = div_hi_ff;
  assign WORD_LENGTH           = lctl_ff[1:0];
  assign TWO_STOP_BITS         = lctl_ff[`UCIL_LC_STOP];
  assign PARITY_ENABLE         = lctl_ff[`UCIL_LC_PEN];
  assign PARITY_EVEN           = lctl_ff[`UCIL_LC_EPS];
  assign PARITY_STICK          = lctl_ff[`UCIL_LC_STICK];
  assign PARITY_STICK_VALUE    = !lctl_ff[`UCIL_LC_EPS];
  assign FIFO_ENABLE           = fifo_en_ff;
  assign HOLDING_EMPTY_FLAG    = hold_empty_ff;
  assign SERIAL_TRANSMIT_OUT   = txo_ff;
  assign CHANNEL_INTERRUPT_OUT = int_ff;

endmodule

/* File: ucil_ctrl_monitor.sv */
/* Port checker for the channel control block.
   Assumes binding onto ucil_ctrl, one clock, synchronous reset. */
`timescale 1ns/1ps
module ucil_ctrl_monitor
#(
  parameter int CW = 12
)
(
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST,
  // Register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Watched outputs
  input wire logic       RX_POP,
  input wire logic       TX_WRITE,
  input wire logic [7:0] TX_DATA,
  input wire logic [7:0] DIVISOR_HIGH,
  input wire logic       FIFO_ENABLE,
  input wire logic       SERIAL_TRANSMIT_OUT,
  input wire logic       CHANNEL_INTERRUPT_OUT
);
  logic [7:0] lc_ff;
  logic [3:0] ien_ff;
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RST);
  //////////////////////////////////////////////////////////////////////
  // Shadows of line control and enables, so bank steering is known
  always_ff @(posedge CLK)
  begin
    if (RST)
      {lc_ff, ien_ff} <= 12'h000;
    else if (WR && ADDR == 3'h3)
      lc_ff <= WDATA;
    else if (WR && ADDR == 3'h1 && !lc_ff[7])
      ien_ff <= WDATA[3:0];
  end
  sequence id_rd;
    RD && ADDR == 3'h2;
  endsequence
  sequence data_rd;
    RD && ADDR == 3'h0 && !lc_ff[7];
  endsequence
  //////////////////////////////////////////////////////////////////////
  ien_read_a: assert property (RD && ADDR == 3'h1 && !lc_ff[7] |=>
    RDATA == {4'h0, $past(ien_ff)}) else $error("enable readback");
  iid_fixed_a: assert property (id_rd |=> RDATA[5:4] == 2'b00 &&
    RDATA[7:6] == {2{$past(FIFO_ENABLE)}}) else $error("id upper bits");
  iid_tout_a: assert property (id_rd |=> !RDATA[3] ||
    (RDATA[2] && RDATA[7])) else $error("id time-out bits");
  data_pop_a: assert property (data_rd |=> RX_POP)
    else $error("no receive pop");
  hold_wr_a: assert property (WR && ADDR == 3'h0 && !lc_ff[7] |=>
    TX_WRITE && TX_DATA == $past(WDATA)) else $error("holding write");
  div_hi_a: assert property (WR && ADDR == 3'h1 && lc_ff[7] |=>
    DIVISOR_HIGH == $past(WDATA)) else $error("divisor high byte");
  break_low_a: assert property (lc_ff[6] && $past(lc_ff[6]) |->
    !SERIAL_TRANSMIT_OUT) else $error("break not low");
  // Three cycles of slack cover the registered interrupt output
  all_off_a: assert property ((ien_ff == 4'h0) [*3] |->
    !CHANNEL_INTERRUPT_OUT) else $error("interrupt while disabled");
endmodule
bind ucil_ctrl ucil_ctrl_monitor #(.CW(CW)) mon
(
  .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .RX_POP(RX_POP), .TX_WRITE(TX_WRITE), .TX_DATA(TX_DATA),
  .DIVISOR_HIGH(DIVISOR_HIGH), .FIFO_ENABLE(FIFO_ENABLE),
  .SERIAL_TRANSMIT_OUT(SERIAL_TRANSMIT_OUT),
  .CHANNEL_INTERRUPT_OUT(CHANNEL_INTERRUPT_OUT)
);

/* File: ucil_host.sv */
/* Host processor model, master of the register port.
   Assumes strobes are sampled on the rising clock edge. */
`timescale 1ns/1ps
module ucil_host
(
  // Clock
  input  wire logic       clk,
  // Register port, master side
  output logic [2:0]      addr,
  output logic [7:0]      wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  initial {addr, wdata, wr, rd} = 13'h0000;
  // One-cycle write; caller clears bit 7 before data accesses
  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle read, data taken one edge later; status is polled
  task automatic rd8(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
endmodule

/* File: tb.sv */
/* Bench for the channel control block, driven by host bus calls.
   Assumes ucil_host as master and the port checker bound in. */
`timescale 1ns/1ps
module tb;
  logic       clk, rst, rx_char, ls_ev, ms_ev, tx_empty, raw;
  logic       wr, rd, intr, sout, stick, rx_rdy, hold;
  logic [2:0] addr;
  logic [4:0] rx_level;
  logic [7:0] d, ls_in, ms_in, wdata, rdata, tx_data, div_lo, div_hi;
  wire  [5:0] fmt;
  logic [7:0] lcv [5] = '{8'h00, 8'h5B, 8'h25, 8'h3F, 8'h43};
  int         num_errors = 0;
  int         n_checks = 0;
  ucil_host h
  (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
  );
  ucil_ctrl #(.CW(12)) dut
  (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .BAUD_TICK(1'b1), .RX_LEVEL(rx_level),
    .RX_CHAR_IN(rx_char), .RX_DATA_READY(rx_rdy), .LS_EVENT(ls_ev),
    .MS_EVENT(ms_ev), .TX_FIFO_EMPTY(tx_empty), .TX_FIFO_PUSH(1'b0),
    .TX_STOP_START(1'b0), .TX_SERIAL_RAW(raw), .LINE_STATUS_IN(ls_in),
    .MODEM_STATUS_IN(ms_in), .RX_POP(), .TX_WRITE(), .TX_DATA(tx_data),
    .DIVISOR_LOW(div_lo), .DIVISOR_HIGH(div_hi), .WORD_LENGTH(fmt[1:0]),
    .TWO_STOP_BITS(fmt[2]), .PARITY_ENABLE(fmt[3]), .PARITY_EVEN(fmt[4]),
    .PARITY_STICK(fmt[5]), .PARITY_STICK_VALUE(stick), .FIFO_ENABLE(),
    .HOLDING_EMPTY_FLAG(hold), .SERIAL_TRANSMIT_OUT(sout),
    .CHANNEL_INTERRUPT_OUT(intr)
  );
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog well past the roughly 1500 cycles the tests need
  initial
  begin
    #2000000;
    num_errors++;
    stop_test();
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    h.rd8(a, d);
    chk(d, e);
  endtask
  // Bounded wait on the interrupt output
  task automatic wait_int(input logic e);
    for (int i = 0; i < 200 && intr !== e; i++)
      @(posedge clk);
    chk({7'h00, intr}, {7'h00, e});
  endtask
  // One-cycle event: 0 char in, 1 line status, 2 modem
  task automatic pulse(input int k);
    {ms_ev, ls_ev, rx_char} <= 3'b001 << k;
    @(posedge clk);
    {ms_ev, ls_ev, rx_char} <= 3'b000;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, rx_char, ls_ev, ms_ev, tx_empty, raw} = 6'b100011;
    rx_level = 5'h00;
    ls_in = 8'h04;
    ms_in = 8'h5A;
    rx_rdy = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rchk(3'h1, 8'h00);
    rchk(3'h2, 8'h01);
    h.wr8(3'h1, 8'hFF);
    rchk(3'h1, 8'h0F);
    h.wr8(3'h4, 8'h55);
    rchk(3'h4, 8'h00);
    h.wr8(3'h1, 8'h01);
    rx_rdy <= 1'b1;
    wait_int(1'b1);
    rchk(3'h2, 8'h04);
    rx_rdy <= 1'b0;
    wait_int(1'b0);
    h.wr8(3'h1, 8'h00);
    $display("test registers done");
    foreach (lcv[i])
    begin
      raw <= lcv[i][0];
      h.wr8(3'h3, lcv[i]);
      rchk(3'h3, lcv[i]);
      chk({2'b00, fmt}, {2'b00, lcv[i][5:0]});
      chk({7'h00, stick}, {7'h00, ~lcv[i][4]});
      chk({7'h00, sout}, {7'h00, ~lcv[i][6] & lcv[i][0]});
    end
    h.wr8(3'h0, 8'h00);
    h.wr8(3'h3, 8'h40);
    rchk(3'h3, 8'h40);
    chk({7'h00, hold}, 8'h01);
    chk({7'h00, sout}, 8'h00);
    h.wr8(3'h3, 8'h00);
    rchk(3'h3, 8'h00);
    chk({7'h00, sout}, 8'h01);
    $display("test format done");
    h.wr8(3'h3, 8'h80);
    h.wr8(3'h0, 8'h12);
    h.wr8(3'h1, 8'h34);
    rchk(3'h1, 8'h34);
    chk(div_lo, 8'h12);
    h.wr8(3'h3, 8'h00);
    h.wr8(3'h1, 8'h00);
    chk(div_hi, 8'h34);
    $display("test divisor done");
    h.wr8(3'h1, 8'h02);
    h.wr8(3'h2, 8'h01);
    wait_int(1'b1);
    rchk(3'h2, 8'hC2);
    wait_int(1'b0);
    rchk(3'h2, 8'hC1);
    h.wr8(3'h2, 8'h00);
    wait_int(1'b1);
    tx_empty <= 1'b0;
    h.wr8(3'h0, 8'hA5);
    wait_int(1'b0);
    chk(tx_data, 8'hA5);
    h.wr8(3'h1, 8'h00);
    h.wr8(3'h2, 8'h41);
    tx_empty <= 1'b1;
    $display("test transmit done");
    h.wr8(3'h1, 8'h0D);
    rx_level <= 5'h01;
    pulse(0);
    pulse(2);
    rchk(3'h2, 8'hC0);
    pulse(1);
    rchk(3'h2, 8'hC6);
    h.rd8(3'h5, d);
    rchk(3'h2, 8'hC0);
    rchk(3'h6, 8'h5A);
    rchk(3'h2, 8'hC1);
    repeat (300) @(posedge clk);
    h.rd8(3'h0, d);
    repeat (300) @(posedge clk);
    chk({7'h00, intr}, 8'h00);
    wait_int(1'b1);
    rchk(3'h2, 8'hCC);
    h.rd8(3'h0, d);
    rx_level <= 5'h00;
    wait_int(1'b0);
    $display("test time-out done");
    rx_level <= 5'h03;
    h.wr8(3'h1, 8'h01);
    rchk(3'h2, 8'hC1);
    rx_level <= 5'h04;
    wait_int(1'b1);
    rchk(3'h2, 8'hC4);
    h.rd8(3'h0, d);
    rx_level <= 5'h03;
    wait_int(1'b0);
    h.wr8(3'h1, 8'h00);
    rx_level <= 5'h05;
    pulse(0);
    repeat (600) @(posedge clk);
    chk({7'h00, intr}, 8'h00);
    rchk(3'h2, 8'hC1);
    $display("test polled done");
    stop_test();
  end
endmodule
